// File: rtl/lbadp_pkg.sv
// Package for the local bus address/data phasing block: register map,
// field positions, reset values, bus-period states and pin bundles.
// Assumes a single 250 MHz system clock and the Avalon-MM register slave.
`default_nettype none

package lbadp_pkg;

    // Widths of the two external buses and of the DRAM column
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int DCOL_W = 9;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_DCOL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_RDATA = 8'h18;

    // Control register fields
    localparam int CTRL_UDA_BIT = 0;
    localparam int CTRL_LDA_BIT = 1;
    localparam int CTRL_BUS8_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // Command register fields; a write to it launches one bus cycle
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_BHE_N_BIT = 1;
    localparam int CMD_REFRESH_BIT = 2;
    localparam int CMD_DRAM_BIT = 3;
    localparam int CMD_USEL_BIT = 4;
    localparam int CMD_LSEL_BIT = 5;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_STRAP_BIT = 1;
    localparam int STAT_HOLD_BIT = 2;
    localparam int STAT_CFG_LSB = 16;

    // Reset values and fixed patterns
    localparam logic STRAP_RST = 1'b1;
    localparam logic [DATA_W-1:0] CFG_RST = 16'h0000;
    localparam logic [DATA_W-1:0] REFRESH_PATTERN = 16'hFFFF;

    // Bus periods as seen by the block
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_T1 = 3'b010,
        ST_T2 = 3'b011,
        ST_T3 = 3'b100,
        ST_TW = 3'b101,
        ST_T4 = 3'b110
    } lbadp_state_e;

    // One latched bus cycle request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DCOL_W-1:0] dcol;
        logic write;
        logic bhe_n;
        logic refresh;
        logic dram;
        logic bus8;
        logic da;
    } lbadp_cyc_s;

    // Everything driven onto the pins, with output enables
    typedef struct packed {
        logic [ADDR_W-1:0] addr_out;
        logic addr_oe;
        logic [DATA_W-1:0] mux_out;
        logic [1:0] mux_oe;
        logic strb_out;
        logic strb_oe;
        logic bhe_n_out;
        logic bhe_oe;
        logic whb_n;
        logic wlb_n;
        logic wstb_oe;
    } lbadp_pins_s;

endpackage : lbadp_pkg

`default_nettype wire

// File: rtl/lbadp_sync.sv
// Two-flop synchroniser bank for pins arriving from outside i_clk.
// Assumes each bit is an independent level; no bit-to-bit coherence.
`default_nettype none

module lbadp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r; // First stage, read only by the second
    logic [W-1:0] sync_r; // Second stage, safe for logic

    // Both stages only shift; reset loads constants
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule : lbadp_sync

`default_nettype wire

// File: rtl/lbadp_bus.sv
// Local bus address/data phasing unit with an Avalon-MM register slave.
// Assumes the bus clock pin is slow (160 ns) against i_clk; pins are
// resolved outside from the out/oe pairs.
// Behaviour
// - addr_bus leads mux_bus by half period
// - Hold or reset floats addr_bus and mux_bus
// - DRAM: odd lines row/column, others steady
// - Address in t1, data t2 to t4
// - Deasserted write strobe floats its byte, except upper byte in 8-bit mode
// - 8-bit regions keep address on upper byte
// - Disabled phase, 8-bit: upper floats t1
// - 8-bit mode: both bytes on lower lines
// - Reset release captures mux_bus configuration
// - Strobe trailing edge sees valid address
// - Emulation mode floats addr_strobe
// - Hold or reset floats addr_strobe low
// - Async ready synchronised, may add period
// - high_byte_enable with bit 0 encodes width
// - high_byte_enable t1 through t3 and waits
// - Refresh: enable high, mux_bus all ones
// - Strap high: region bit suppresses t1 address
// - Strap sampled at reset rise; low forces address
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`default_nettype none

module lbadp_bus
    import lbadp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    // Avalon-MM slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Pins from the outside world
    input wire logic i_sys_clock_out,
    input wire logic i_async_ready_in,
    input wire logic i_sync_ready_in,
    input wire logic i_hold,
    input wire logic i_on_circuit_emul_mode,
    input wire logic i_reset_in_n,
    input wire logic i_addr_phase_strap,
    input wire logic [DATA_W-1:0] i_mux_bus,
    // Pins to the outside world
    output logic [ADDR_W-1:0] o_addr_bus,
    output logic o_addr_bus_oe,
    output logic [DATA_W-1:0] o_mux_bus,
    output logic [1:0] o_mux_bus_oe,
    output logic o_addr_strobe,
    output logic o_addr_strobe_oe,
    output logic o_high_byte_enable_n,
    output logic o_high_byte_enable_oe,
    output logic o_upper_write_strobe_n,
    output logic o_lower_write_strobe_n,
    output logic o_write_strobe_oe,
    output logic o_hold_ack
);

    localparam int SYNC_W = 7 + DATA_W;

    logic [SYNC_W-1:0] sync_s; // Synchronised pin levels
    logic clk_s, async_ready_in_s, sync_ready_in_s, hold_s, on_circuit_emul_mode_s, rstn_s, strap_s;
    logic [DATA_W-1:0] mux_in_s;
    logic rise, fall, rst_cond, ready;

    // Software-side state
    logic [2:0] ctrl_r, ctrl_nxt;                 // Region disables, 8-bit mode
    logic [ADDR_W-1:0] addr_r, addr_nxt;          // Staged address
    logic [DATA_W-1:0] wdata_r, wdata_nxt;        // Staged write data
    logic [DCOL_W-1:0] dcol_r, dcol_nxt;          // Staged DRAM column
    logic wait_r, wait_nxt;                       // Registered waitrequest
    logic [31:0] rdata_r, rdata_nxt;              // Registered readdata
    logic go_r, go_nxt;                           // Cycle launched, not started
    lbadp_cyc_s cyc_r, cyc_nxt;                   // Latched cycle
    logic busy, do_wr, accept;

    // Link-side state
    lbadp_state_e state_r, state_nxt;
    logic strb_r, strb_nxt;                       // Address strobe level
    logic hold_ack_r, hold_ack_nxt;
    logic strap_r, strap_nxt;                     // Captured address-phase strap
    logic [DATA_W-1:0] cfg_r, cfg_nxt;            // Reset configuration word
    logic [DATA_W-1:0] bus_rd_r, bus_rd_nxt;      // Data read from the bus
    logic clk_q_r, rstn_q_r;                      // Previous synced levels
    lbadp_pins_s pin_r, pin_nxt;
    logic go_clr;

    // Every outside pin passes two flops before use
    lbadp_sync #(.W(SYNC_W)) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async({i_sys_clock_out, i_async_ready_in, i_sync_ready_in, i_hold,
                  i_on_circuit_emul_mode, i_reset_in_n, i_addr_phase_strap,
                  i_mux_bus}),
        .o_sync(sync_s)
    );

    assign {clk_s, async_ready_in_s, sync_ready_in_s, hold_s, on_circuit_emul_mode_s, rstn_s, strap_s, mux_in_s} = sync_s;
    assign rise = clk_s & ~clk_q_r;
    assign fall = ~clk_s & clk_q_r;
    assign rst_cond = ~rstn_s;
    // Either ready source completes the cycle; async path costs two flops
    assign ready = async_ready_in_s | sync_ready_in_s;
    assign busy = go_r | (state_r != ST_IDLE);

    // Byte-lane merge for Avalon writes
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Register slave: one wait cycle per access, command stalls while busy
    always_comb begin
        ctrl_nxt = ctrl_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        dcol_nxt = dcol_r;
        cyc_nxt = cyc_r;
        go_nxt = go_r & ~go_clr;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        // Back-pressure: a new command waits for the previous cycle
        accept = (i_avs_read | i_avs_write) & wait_r &
                 ~(i_avs_write & (i_avs_address == OFS_CMD) & busy);
        do_wr = i_avs_write & ~wait_r;
        if (accept) begin
            wait_nxt = 1'b0;
        end
        // Read decode; unmapped offsets read zero
        if (accept & i_avs_read) begin
            if (i_avs_address == OFS_CTRL) begin
                rdata_nxt = {29'h0, ctrl_r};
            end else if (i_avs_address == OFS_ADDR) begin
                rdata_nxt = {12'h0, addr_r};
            end else if (i_avs_address == OFS_WDATA) begin
                rdata_nxt = {16'h0, wdata_r};
            end else if (i_avs_address == OFS_DCOL) begin
                rdata_nxt = {23'h0, dcol_r};
            end else if (i_avs_address == OFS_STAT) begin
                rdata_nxt = 32'h0;
                rdata_nxt[STAT_BUSY_BIT] = busy;
                rdata_nxt[STAT_STRAP_BIT] = strap_r;
                rdata_nxt[STAT_HOLD_BIT] = hold_ack_r;
                rdata_nxt[STAT_CFG_LSB +: DATA_W] = cfg_r;
            end else if (i_avs_address == OFS_RDATA) begin
                rdata_nxt = {16'h0, bus_rd_r};
            end else begin
                rdata_nxt = 32'h0;
            end
        end
        // Writes land on the edge that sees waitrequest low
        if (do_wr) begin
            if (i_avs_address == OFS_CTRL) begin
                ctrl_nxt = 3'(be_merge({29'h0, ctrl_r}, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address == OFS_ADDR) begin
                addr_nxt = 20'(be_merge({12'h0, addr_r}, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address == OFS_WDATA) begin
                wdata_nxt = 16'(be_merge({16'h0, wdata_r}, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address == OFS_DCOL) begin
                dcol_nxt = 9'(be_merge({23'h0, dcol_r}, i_avs_writedata, i_avs_byteenable));
            end else if (i_avs_address == OFS_CMD) begin
                cyc_nxt.addr = addr_r;
                cyc_nxt.wdata = wdata_r;
                cyc_nxt.dcol = dcol_r;
                cyc_nxt.write = i_avs_writedata[CMD_WRITE_BIT];
                cyc_nxt.bhe_n = i_avs_writedata[CMD_BHE_N_BIT];
                cyc_nxt.refresh = i_avs_writedata[CMD_REFRESH_BIT];
                cyc_nxt.dram = i_avs_writedata[CMD_DRAM_BIT];
                cyc_nxt.bus8 = ctrl_r[CTRL_BUS8_BIT];
                // Suppression only when the strap allowed it
                cyc_nxt.da = strap_r &
                    ((i_avs_writedata[CMD_USEL_BIT] & ctrl_r[CTRL_UDA_BIT]) |
                     (i_avs_writedata[CMD_LSEL_BIT] & ctrl_r[CTRL_LDA_BIT]));
                go_nxt = 1'b1;
            end
        end
    end

    // Software-side registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_r <= CTRL_RST;
            addr_r <= '0;
            wdata_r <= '0;
            dcol_r <= '0;
            cyc_r <= '0;
            go_r <= 1'b0;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            dcol_r <= dcol_nxt;
            cyc_r <= cyc_nxt;
            go_r <= go_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
        end
    end

    // Bus period sequencing and pin values for the next state
    always_comb begin
        state_nxt = state_r;
        go_clr = 1'b0;
        strap_nxt = strap_r;
        cfg_nxt = cfg_r;
        bus_rd_nxt = bus_rd_r;
        // Hold is granted only between cycles
        hold_ack_nxt = ~rst_cond & hold_s & (hold_ack_r | (state_r == ST_IDLE));
        // Reset release latches strap and configuration word
        if (rstn_s & ~rstn_q_r) begin
            strap_nxt = strap_s;
            cfg_nxt = mux_in_s;
        end
        if (rst_cond) begin
            state_nxt = ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // Address bus starts on a falling edge, half a period early
                    if (go_r & ~hold_ack_r & ~hold_s & fall) begin
                        state_nxt = ST_PRE;
                        go_clr = 1'b1;
                    end
                end
                ST_PRE: if (rise) state_nxt = ST_T1;
                ST_T1: if (rise) state_nxt = ST_T2;
                ST_T2: if (rise) state_nxt = ST_T3;
                ST_T3, ST_TW: begin
                    // Stretch with waits until ready is seen
                    if (rise) begin
                        state_nxt = ready ? ST_T4 : ST_TW;
                    end
                end
                ST_T4: if (rise) state_nxt = ST_IDLE;
                default: state_nxt = ST_IDLE;
            endcase
        end
        // Capture read data as the cycle enters t4; 8-bit lands per bit 0
        if ((state_nxt == ST_T4) & (state_r != ST_T4) & ~cyc_r.write) begin
            if (cyc_r.bus8) begin
                bus_rd_nxt = cyc_r.addr[0] ? {mux_in_s[7:0], bus_rd_r[7:0]}
                                           : {bus_rd_r[15:8], mux_in_s[7:0]};
            end else begin
                bus_rd_nxt = mux_in_s;
            end
        end
        // Strobe rises entering t1 and falls mid t1, address already out
        if ((state_nxt == ST_T1) & (state_r == ST_PRE)) begin
            strb_nxt = 1'b1;
        end else if ((state_nxt != ST_T1) | fall) begin
            strb_nxt = 1'b0;
        end else begin
            strb_nxt = strb_r;
        end
        pin_nxt = '0;
        pin_nxt.bhe_n_out = 1'b1;
        pin_nxt.whb_n = 1'b1;
        pin_nxt.wlb_n = 1'b1;
        // Emulation mode leaves the strobe undriven; float hold/reset too
        pin_nxt.strb_oe = ~on_circuit_emul_mode_s & ~rst_cond & ~hold_ack_nxt;
        pin_nxt.strb_out = strb_nxt & pin_nxt.strb_oe;
        // Everything else is floated by hold or reset
        if (~rst_cond & ~hold_ack_nxt & (state_nxt != ST_IDLE)) begin
            pin_nxt.addr_oe = 1'b1;
            pin_nxt.addr_out = cyc_r.addr;
            // DRAM column goes on the odd lines from t3; even lines untouched
            if (cyc_r.dram & (state_nxt inside {ST_T3, ST_TW, ST_T4})) begin
                for (int i = 0; i < DCOL_W; i++) begin
                    pin_nxt.addr_out[2*i+1] = cyc_r.dcol[i];
                end
            end
            pin_nxt.bhe_oe = 1'b1;
            pin_nxt.wstb_oe = 1'b1;
            // Byte enable held t1 to t3 and waits, released in t4
            if (state_nxt inside {ST_T1, ST_T2, ST_T3, ST_TW}) begin
                pin_nxt.bhe_n_out = cyc_r.bhe_n | cyc_r.refresh;
            end
            if (state_nxt == ST_T1) begin
                // Address phase, or all ones for refresh, unless suppressed
                pin_nxt.mux_out = cyc_r.refresh ? REFRESH_PATTERN
                                                : cyc_r.addr[DATA_W-1:0];
                pin_nxt.mux_oe = {2{~cyc_r.da}};
            end else if (state_nxt != ST_PRE) begin
                // Data phase t2..t4, strobes follow the byte encoding
                pin_nxt.whb_n = ~(cyc_r.write & ~cyc_r.bhe_n & ~cyc_r.bus8);
                pin_nxt.wlb_n = ~(cyc_r.write & (~cyc_r.addr[0] | cyc_r.bus8));
                pin_nxt.mux_oe[0] = ~pin_nxt.wlb_n;
                pin_nxt.mux_out[7:0] = (cyc_r.bus8 & cyc_r.addr[0]) ? cyc_r.wdata[15:8]
                                                                     : cyc_r.wdata[7:0];
                if (cyc_r.bus8) begin
                    pin_nxt.mux_oe[1] = 1'b1;
                    pin_nxt.mux_out[15:8] = cyc_r.addr[15:8];
                end else begin
                    pin_nxt.mux_oe[1] = ~pin_nxt.whb_n;
                    pin_nxt.mux_out[15:8] = cyc_r.wdata[15:8];
                end
            end
        end
    end

    // Link-side registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            strb_r <= 1'b0;
            hold_ack_r <= 1'b0;
            strap_r <= STRAP_RST;
            cfg_r <= CFG_RST;
            bus_rd_r <= '0;
            clk_q_r <= 1'b0;
            rstn_q_r <= 1'b0;
            pin_r <= '0;
        end else begin
            state_r <= state_nxt;
            strb_r <= strb_nxt;
            hold_ack_r <= hold_ack_nxt;
            strap_r <= strap_nxt;
            cfg_r <= cfg_nxt;
            bus_rd_r <= bus_rd_nxt;
            clk_q_r <= clk_s;
            rstn_q_r <= rstn_s;
            pin_r <= pin_nxt;
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_addr_bus = pin_r.addr_out;
    assign o_addr_bus_oe = pin_r.addr_oe;
    assign o_mux_bus = pin_r.mux_out;
    assign o_mux_bus_oe = pin_r.mux_oe;
    assign o_addr_strobe = pin_r.strb_out;
    assign o_addr_strobe_oe = pin_r.strb_oe;
    assign o_high_byte_enable_n = pin_r.bhe_n_out;
    assign o_high_byte_enable_oe = pin_r.bhe_oe;
    assign o_upper_write_strobe_n = pin_r.whb_n;
    assign o_lower_write_strobe_n = pin_r.wlb_n;
    assign o_write_strobe_oe = pin_r.wstb_oe;
    assign o_hold_ack = hold_ack_r;

    // Checks on the pin sequencing
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_wait_entry;
        (state_r == ST_T3) && rise && !ready;
    endsequence

    AST_FLOAT_RESET: assert property (rst_cond |=> !o_addr_bus_oe && o_mux_bus_oe == 2'b00)
        else $error("bus driven during reset condition");
    AST_ADDR_LEADS: assert property ($rose(o_mux_bus_oe[0]) && state_r == ST_T1 |->
        $past(o_addr_bus_oe) && $past(state_r) == ST_PRE)
        else $error("mux address before address bus");
    AST_DRAM_EVEN: assert property (cyc_r.dram && o_addr_bus_oe && $past(o_addr_bus_oe) |->
        $stable(o_addr_bus & 20'hD5555))
        else $error("DRAM even lines moved");
    AST_T1_ADDR: assert property (state_r == ST_T1 && o_mux_bus_oe[0] && !cyc_r.refresh |->
        o_mux_bus == cyc_r.addr[15:0])
        else $error("t1 not carrying address");
    AST_UPPER_FLOAT: assert property (state_r inside {ST_T2, ST_T3, ST_TW, ST_T4} &&
        o_upper_write_strobe_n && !cyc_r.bus8 |-> !o_mux_bus_oe[1])
        else $error("upper byte driven with strobe off");
    AST_BUS8_UPPER: assert property (cyc_r.bus8 && state_r == ST_T2 && o_addr_bus_oe |->
        o_mux_bus_oe[1] && o_mux_bus[15:8] == cyc_r.addr[15:8])
        else $error("8-bit upper byte lost address");
    AST_STROBE_EMUL: assert property (on_circuit_emul_mode_s |=> !o_addr_strobe_oe)
        else $error("strobe driven in emulation mode");
    AST_REFRESH: assert property (state_r == ST_T1 && cyc_r.refresh && o_mux_bus_oe[0] |->
        o_mux_bus == REFRESH_PATTERN && o_high_byte_enable_n)
        else $error("refresh pattern wrong");
    AST_WAIT: assert property (s_wait_entry |=> state_r == ST_TW [*2])
        else $error("wait period not inserted");
    AST_SUPPRESS: assert property (state_r == ST_T1 && cyc_r.da |-> o_mux_bus_oe == 2'b00)
        else $error("address phase not suppressed");

endmodule : lbadp_bus

`default_nettype wire

// File: verification/lbadp_far_model.sv
// Far-side model: memories on mux_bus, reset config and ready lines.
// Assumes the bench says when a read is in flight.
`default_nettype none
module lbadp_far_model (
    input wire logic i_clk,
    input wire logic i_sclk,
    input wire logic i_reset_in_n,
    input wire logic i_drive,
    input wire logic [1:0] i_waits,
    input wire logic [15:0] i_cfg,
    input wire logic [15:0] i_rdata,
    input wire logic [15:0] i_mux_out,
    input wire logic [1:0] i_mux_oe,
    input wire logic i_strobe,
    output logic [15:0] o_mux,
    output logic o_async_ready_in,
    output logic o_sync_ready_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_r = 16'h0000; // Last resolved level
    logic [2:0] cnt_r = 3'h7; // Bus periods since the strobe
    logic [3:0] rel_r = 4'h0; // Reset pin level over the last cycles
    // Configuration stays driven a few cycles past reset release as hold time
    always_ff @(posedge i_clk) rel_r <= {rel_r[2:0], i_reset_in_n};
    // Unused asynchronous ready stays low
    assign o_async_ready_in = 1'b0;
    assign o_sync_ready_in = cnt_r > 3'(i_waits) + 3'h1;
    // A strobe restarts the wait count
    always @(posedge i_sclk or posedge i_strobe) begin
        if (i_strobe) cnt_r <= 3'h0;
        else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
    end
    // Released bytes show config during reset and just after, read data in a read, else the inverse of the last level
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            o_mux[b*8+:8] = i_mux_oe[b] ? i_mux_out[b*8+:8] :
                !rel_r[3] ? i_cfg[b*8+:8] :
                i_drive ? i_rdata[b*8+:8] : ~last_r[b*8+:8];
        end
    end
    always_ff @(posedge i_clk) last_r <= o_mux;
endmodule : lbadp_far_model
`default_nettype wire

// File: verification/testbench.sv
// Bench for lbadp_bus: random bus cycles launched through the Avalon slave.
// Assumes the far-side model resolves mux_bus and answers ready.
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, s); num_errors++; end end
module testbench import lbadp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_srst = 1, rd = 0, wr = 0, sclk = 0, hold = 0, emul = 0, stp = 1, dr;
    logic [8:0] dc;
    logic rstn = 0, drive = 0, async_ready_in, sync_ready_in, stq, t1b, w, rf, us, ls, bh, supp;
    logic abo, st, sto, high_byte_enable, bho, wu, wl, wso, hack, wreq;
    logic [7:0] ad = 0;
    logic [31:0] wd = 0, q, rdd, r;
    logic [15:0] cfg, pd = 0, mi, mo, t1m, dm, wdat, de;
    logic [19:0] ab, t1a, a, t4a;
    logic [2:0] c, emq = 0;
    logic [1:0] moe, t1o, dox, doe, wt = 0;
    int num_errors = 0, comparisons = 0, seed = 41, cyc = 0;
    always #2 i_clk = ~i_clk;
    // Bus clock runs free, phase unrelated to i_clk
    initial begin #37; forever #80 sclk = ~sclk; end
    lbadp_bus lbadp_bus_inst (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(ad),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdd), .o_avs_waitrequest(wreq),
        .i_sys_clock_out(sclk), .i_async_ready_in(async_ready_in), .i_sync_ready_in(sync_ready_in),
        .i_hold(hold), .i_on_circuit_emul_mode(emul), .i_reset_in_n(rstn),
        .i_addr_phase_strap(stp), .i_mux_bus(mi), .o_addr_bus(ab),
        .o_addr_bus_oe(abo), .o_mux_bus(mo), .o_mux_bus_oe(moe), .o_addr_strobe(st),
        .o_addr_strobe_oe(sto), .o_high_byte_enable_n(high_byte_enable),
        .o_high_byte_enable_oe(bho), .o_upper_write_strobe_n(wu),
        .o_lower_write_strobe_n(wl), .o_write_strobe_oe(wso), .o_hold_ack(hack));
    lbadp_far_model lbadp_far_model_inst (.i_clk(i_clk), .i_sclk(sclk),
        .i_reset_in_n(rstn), .i_drive(drive), .i_waits(wt), .i_cfg(cfg),
        .i_rdata(pd), .i_mux_out(mo), .i_mux_oe(moe), .i_strobe(st && sto),
        .o_mux(mi), .o_async_ready_in(async_ready_in), .o_sync_ready_in(sync_ready_in));
    function automatic logic [15:0] bm(input logic [1:0] o);
        return {{8{o[1]}}, {8{o[0]}}};
    endfunction : bm
    // Address late in a cycle: DRAM puts the column on the odd lines
    function automatic logic [19:0] late_addr(input logic [19:0] ax, input logic [8:0] cx,
        input logic en);
        logic [19:0] v;
        v = ax;
        for (int k = 0; k < 9; k++) if (en) v[2*k+1] = cx[k];
        return v;
    endfunction : late_addr
    task automatic conclude();
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // One Avalon transfer, held until waitrequest is seen low
    task automatic av(input logic wn, input logic [7:0] ax, input logic [31:0] d,
        output logic [31:0] qq);
        @(posedge i_clk);
        rd <= !wn;
        wr <= wn;
        ad <= ax;
        wd <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        qq = rdd;
        rd <= 0;
        wr <= 0;
    endtask : av
    // Capture the t1 address at strobe rise and data while a write strobe is low
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        stq <= st;
        if (st && !stq) begin t1m <= mo; t1o <= moe; t1a <= ab; t1b <= high_byte_enable; end
        if (wso && !(wu && wl)) begin dm <= mo; dox <= moe; end
        if (abo) t4a <= ab;
        // Emulation pin needs sync plus register before the strobe lets go
        emq <= {emq[1:0], emul};
        if (&emq && emul && sto) `CHK("strobe_oe", 1'b0, sto)
        if (cyc == 20000) begin num_errors++; conclude(); end
    end
    initial begin
        cfg = 16'($random(seed));
        repeat (16) @(posedge i_clk);
        i_srst <= 0;
        repeat (8) @(posedge i_clk);
        rstn <= 1;
        repeat (8) @(posedge i_clk);
        av(0, OFS_CTRL, 0, q);
        `CHK("ctrl", CTRL_RST, q[2:0])
        av(0, 8'h1C, 0, q);
        `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < 14; i++) begin
            if (i == 12) begin
                // Second pin reset mid-run, strap now held low
                stp <= 0;
                rstn <= 0;
                cfg <= 16'($random(seed));
                repeat (8) @(posedge i_clk);
                rstn <= 1;
                repeat (8) @(posedge i_clk);
            end
            if (i % 12 == 0) begin
                av(0, OFS_STAT, 0, q);
                `CHK("cfg", cfg, q[31:16])
                `CHK("strap", stp, q[STAT_STRAP_BIT])
            end
            c = 3'($random(seed));
            a = 20'($random(seed));
            wdat = 16'($random(seed));
            r = $random(seed);
            rf = r[3:1] == 0;
            dr = r[7] && !rf;
            dc = 9'($random(seed));
            w = r[0] && !rf;
            us = r[4] && !rf;
            ls = r[5] && !rf && !us;
            if (c[2]) bh = ~a[0];
            else begin bh = r[6]; if (bh) a[0] = 0; end
            emul <= i == 11;
            pd <= 16'($random(seed));
            drive <= !w;
            wt <= r[9:8];
            av(1, OFS_CTRL, 32'(c), q);
            av(1, OFS_ADDR, 32'(a), q);
            av(1, OFS_WDATA, 32'(wdat), q);
            av(1, OFS_DCOL, 32'(dc), q);
            t1o <= 'x;
            dox <= 'x;
            av(1, OFS_CMD, 32'({ls, us, dr, rf, bh, w}), q);
            do av(0, OFS_STAT, 0, q); while (q[STAT_BUSY_BIT] !== 1'b0);
            supp = stp && !rf && (us && c[0] || ls && c[1]);
            de = (rf ? 16'hFFFF : a[15:0]) & {16{!supp}};
            doe = c[2] ? 2'b11 : {!bh, !a[0]};
            if (!emul) begin
                `CHK("t1_oe", supp ? 2'b00 : 2'b11, t1o)
                `CHK("t1_mux", de, t1m & {16{!supp}})
                `CHK("t1_bhe", rf || bh, t1b)
                if (!rf) `CHK("t1_addr", a, t1a)
            end
            if (!rf) `CHK("late_addr", late_addr(a, dc, dr), t4a)
            de = c[2] ? {a[15:8], a[0] ? wdat[15:8] : wdat[7:0]} : wdat;
            if (w) begin
                `CHK("d_oe", doe, dox)
                `CHK("d_mux", de & bm(doe), dm & bm(doe))
            end else if (!rf) begin
                av(0, OFS_RDATA, 0, q);
                de = c[2] ? {2{pd[7:0]}} : pd;
                if (c[2]) doe = {a[0], !a[0]};
                `CHK("rdata", de & bm(doe), q[15:0] & bm(doe))
            end
        end
        hold <= 1;
        while (hack !== 1'b1) @(negedge i_clk);
        `CHK("hold_oe", 6'h00, {abo, moe, sto, bho, wso})
        conclude();
    end
endmodule : testbench
`default_nettype wire
